// ==== src/tcs_pkg.sv ====
// Shared constants of the transceiver control/status pair.
// Assumes one 200 MHz system clock on both ends.
`default_nettype none

package tcs_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CLK_KHZ = 200000;

  // Pin timing
  localparam int T_RESET_US   = 10;
  localparam int RESET_CYCLES = T_RESET_US * CLK_MHZ;
  localparam int T_BUF_US     = 20;
  localparam int BUF_CYCLES   = T_BUF_US * CLK_MHZ;
  localparam int F_SCL_KHZ    = 100;
  // Rounded up so the bus never runs faster than allowed
  localparam int QUARTER_CYCLES = (CLK_KHZ + 4 * F_SCL_KHZ - 1) / (4 * F_SCL_KHZ);

  // Long times, used as parameter defaults
  localparam int T_SERIAL_MS   = 300;
  localparam int T_DATA_MS     = 1000;
  localparam int T_WRITE_MS    = 10;
  localparam int SERIAL_CYCLES = T_SERIAL_MS * CLK_KHZ;
  localparam int DATA_CYCLES   = T_DATA_MS * CLK_KHZ;
  localparam int WRITE_CYCLES  = T_WRITE_MS * CLK_KHZ;

  // Two-wire device addresses (7-bit) and the status/control byte
  localparam logic [6:0] ID_DEV      = 7'h50;
  localparam logic [6:0] DIAG_DEV    = 7'h51;
  localparam logic [7:0] STATUS_BYTE = 8'h6E;
  localparam int SOFT_OFF_BIT   = 6;
  localparam int SOFT_FAULT_BIT = 2;
  localparam int SOFT_LOS_BIT   = 1;
  localparam int DATA_RDY_BIT   = 0;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Host controller registers on AHB-Lite
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] EVT_OFS  = 8'h0C;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam int CTRL_HWOFF_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CMD_ADDR_LSB   = 8;
  localparam int CMD_RD_BIT     = 16;
  localparam int CMD_DIAG_BIT   = 17;
  localparam int STAT_RDATA_LSB = 8;
  localparam int EVT_DONE  = 0;
  localparam int EVT_FAULT = 1;
  localparam int EVT_LOS   = 2;
endpackage

`default_nettype wire

// ==== src/tcs_link_if.sv ====
// Pins between host board controller and transceiver module.
// SDA is open drain with a pull-up; resolved here from both enables.
`default_nettype none

interface tcs_link_if;
  logic txDisable;
  logic txFault;
  logic rxSignalLost;
  logic scl;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic sda;

  assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

  modport host(
    output txDisable, scl, sdaHostOut, sdaHostOe,
    input  txFault, rxSignalLost, sda
  );
  modport dev(
    output txFault, rxSignalLost, sdaDevOut, sdaDevOe,
    input  txDisable, scl, sda
  );
endinterface

`default_nettype wire

// ==== src/tcs_module_end.sv ====
// Transceiver module end: pin control, fault latch, two-wire slave.
// Assumes laserFault and opticalPresent come from logic on clk.
// Behaviour
// - Hardware off input kills light within 10 us
// - Hardware off release restores light within 1 ms
// - Init and fault clear within 300 ms
// - Fault pin asserts within 100 us
// - Off held 10 us clears latched fault
// - Signal-lost pin asserts within 100 us
// - Signal-lost pin deasserts within 100 us
// - Soft off bit kills light within 100 ms
// - Soft off clear restores light within 100 ms
// - Soft fault bit set within 100 ms
// - Soft signal-lost bit follows within 100 ms
// - Monitor ready bit within 1000 ms
// - Serial access only after 300 ms
// - Host idles 20 us between stop and start
// - Write cycle lasts up to 10 ms
// - Host clocks bus at most 100 kHz
`default_nettype none

module tcs_module_end #(
  parameter int BusReadyCycles  = tcs_pkg::SERIAL_CYCLES,
  parameter int DataReadyCycles = tcs_pkg::DATA_CYCLES,
  parameter int WriteCycles     = tcs_pkg::WRITE_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  tcs_link_if.dev     link,
  input  wire logic   laserFault,
  input  wire logic   opticalPresent,
  output var  logic   laserOn,
  output var  logic   monitorReady
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_ACKW,
    S_ACKH,
    S_TX,
    S_MACK,
    S_LOAD
  } tcs_slv_e;

  typedef struct packed {
    logic [1:0]  txdS;
    logic [1:0]  sclS;
    logic [1:0]  sdaS;
    logic        sclPrev;
    logic        sdaPrev;
    tcs_slv_e    st;
    logic [2:0]  cnt;
    logic [7:0]  sh;
    logic [1:0]  byteNo;
    logic        rw;
    logic        diag;
    logic        ackOk;
    logic        wrote;
    logic        softOff;
    logic        softStage;
    logic [7:0]  ptr;
    logic        sdaDrv;
    logic        fault;
    logic [11:0] clrCnt;
    logic [31:0] upCnt;
    logic        busReady;
    logic        dataReady;
    logic        busy;
    logic [31:0] wrCnt;
    logic        laserOn;
    logic        los;
  } tcs_dev_s;

  tcs_dev_s s_ff;
  tcs_dev_s nxt_s;

  function automatic logic [7:0] readByte(input tcs_dev_s s);
    logic [7:0] b;
    b = 8'h00;
    if (s.diag && s.ptr == tcs_pkg::STATUS_BYTE) begin
      b[tcs_pkg::SOFT_OFF_BIT]   = s.softOff;
      b[tcs_pkg::SOFT_FAULT_BIT] = s.fault;
      b[tcs_pkg::SOFT_LOS_BIT]   = s.los;
      b[tcs_pkg::DATA_RDY_BIT]   = s.dataReady;
    end
    return b;
  endfunction

  always_comb begin
    logic       sclRise;
    logic       sclFall;
    logic       sdaIn;
    logic       start;
    logic       stop;
    logic [7:0] rxByte;
    sclRise = s_ff.sclS[1] && !s_ff.sclPrev;
    sclFall = !s_ff.sclS[1] && s_ff.sclPrev;
    sdaIn   = s_ff.sdaS[1];
    start   = s_ff.sclS[1] && s_ff.sclPrev && s_ff.sdaPrev && !sdaIn;
    stop    = s_ff.sclS[1] && s_ff.sclPrev && !s_ff.sdaPrev && sdaIn;
    rxByte  = {s_ff.sh[6:0], sdaIn};
    nxt_s   = s_ff;

    // Pins from the host pass two flops before use
    nxt_s.txdS    = {s_ff.txdS[0], link.txDisable};
    nxt_s.sclS    = {s_ff.sclS[0], link.scl};
    nxt_s.sdaS    = {s_ff.sdaS[0], link.sda};
    nxt_s.sclPrev = s_ff.sclS[1];
    nxt_s.sdaPrev = s_ff.sdaS[1];

    // Power-up timers; data ready assumed later than bus ready
    if (s_ff.upCnt != 32'(DataReadyCycles)) begin
      nxt_s.upCnt = s_ff.upCnt + 32'h1;
    end
    nxt_s.busReady  = s_ff.upCnt >= 32'(BusReadyCycles);
    nxt_s.dataReady = s_ff.upCnt == 32'(DataReadyCycles);

    // Fault latch: a new fault wins over a clearing pulse
    if (s_ff.txdS[1]) begin
      if (s_ff.clrCnt != 12'(tcs_pkg::RESET_CYCLES - 1)) begin
        nxt_s.clrCnt = s_ff.clrCnt + 12'h1;
      end
    end else begin
      nxt_s.clrCnt = 12'h000;
    end
    nxt_s.fault = (s_ff.fault && !(s_ff.txdS[1]
                   && s_ff.clrCnt == 12'(tcs_pkg::RESET_CYCLES - 1)))
                  || laserFault;
    nxt_s.los = !opticalPresent;

    // Internal write cycle
    if (s_ff.busy) begin
      nxt_s.wrCnt = s_ff.wrCnt + 32'h1;
      if (s_ff.wrCnt == 32'(WriteCycles - 1)) begin
        nxt_s.busy = 1'b0;
      end
    end

    // Two-wire slave
    if (start) begin
      nxt_s.st     = S_RX;
      nxt_s.cnt    = 3'h0;
      nxt_s.byteNo = 2'h0;
      nxt_s.sdaDrv = 1'b0;
    end else if (stop) begin
      nxt_s.st     = S_IDLE;
      nxt_s.sdaDrv = 1'b0;
      if (s_ff.wrote) begin
        nxt_s.softOff = s_ff.softStage;
        nxt_s.busy    = 1'b1;
        nxt_s.wrCnt   = 32'h0;
        nxt_s.wrote   = 1'b0;
      end
    end else begin
      case (s_ff.st)
        S_RX: begin
          if (sclRise) begin
            nxt_s.sh  = rxByte;
            nxt_s.cnt = s_ff.cnt + 3'h1;
            if (s_ff.cnt == tcs_pkg::LAST_BIT) begin
              nxt_s.st    = S_ACKW;
              nxt_s.ackOk = 1'b1;
              if (s_ff.byteNo == 2'h0) begin
                nxt_s.rw    = sdaIn;
                nxt_s.diag  = s_ff.sh[6:0] == tcs_pkg::DIAG_DEV;
                nxt_s.ackOk = s_ff.busReady && !s_ff.busy
                              && (s_ff.sh[6:0] == tcs_pkg::DIAG_DEV
                                  || s_ff.sh[6:0] == tcs_pkg::ID_DEV);
              end else if (s_ff.byteNo == 2'h1) begin
                nxt_s.ptr = rxByte;
              end else begin
                if (s_ff.diag && s_ff.ptr == tcs_pkg::STATUS_BYTE) begin
                  nxt_s.softStage = rxByte[tcs_pkg::SOFT_OFF_BIT];
                end
                nxt_s.wrote = 1'b1;
                nxt_s.ptr   = s_ff.ptr + 8'h01;
              end
            end
          end
        end
        S_ACKW: begin
          if (sclFall) begin
            nxt_s.sdaDrv = s_ff.ackOk;
            nxt_s.st     = s_ff.ackOk ? S_ACKH : S_IDLE;
          end
        end
        S_ACKH: begin
          if (sclFall) begin
            nxt_s.cnt = 3'h0;
            if (s_ff.byteNo != 2'h2) begin
              nxt_s.byteNo = s_ff.byteNo + 2'h1;
            end
            if (s_ff.rw) begin
              nxt_s.sh     = readByte(s_ff);
              nxt_s.sdaDrv = !nxt_s.sh[7];
              nxt_s.st     = S_TX;
            end else begin
              nxt_s.sdaDrv = 1'b0;
              nxt_s.st     = S_RX;
            end
          end
        end
        S_TX: begin
          if (sclFall) begin
            if (s_ff.cnt == tcs_pkg::LAST_BIT) begin
              nxt_s.sdaDrv = 1'b0;
              nxt_s.st     = S_MACK;
            end else begin
              nxt_s.cnt    = s_ff.cnt + 3'h1;
              nxt_s.sh     = {s_ff.sh[6:0], 1'b1};
              nxt_s.sdaDrv = !s_ff.sh[6];
            end
          end
        end
        S_MACK: begin
          if (sclRise) begin
            nxt_s.ptr = s_ff.ptr + 8'h01;
            // No acknowledge from the host ends the read
            nxt_s.st  = sdaIn ? S_IDLE : S_LOAD;
          end
        end
        S_LOAD: begin
          if (sclFall) begin
            nxt_s.cnt    = 3'h0;
            nxt_s.sh     = readByte(s_ff);
            nxt_s.sdaDrv = !nxt_s.sh[7];
            nxt_s.st     = S_TX;
          end
        end
        default: begin
          nxt_s.st     = S_IDLE;
          nxt_s.sdaDrv = 1'b0;
        end
      endcase
    end

    // Either off source, or a latched fault, darkens the laser
    nxt_s.laserOn = !(s_ff.txdS[1] || s_ff.softOff || s_ff.fault);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.txFault      = s_ff.fault;
  assign link.rxSignalLost = s_ff.los;
  assign link.sdaDevOut    = 1'b0;
  assign link.sdaDevOe     = s_ff.sdaDrv;
  assign laserOn           = s_ff.laserOn;
  assign monitorReady      = s_ff.dataReady;

endmodule

`default_nettype wire

// ==== src/tcs_host_end.sv ====
// Host board controller end: AHB-Lite registers, pin control, two-wire master.
// Assumes one AHB-Lite master; the bus only sees single word transfers.
//
// Design decision made here: the AHB-Lite interface to the registers.
`default_nettype none

module tcs_host_end #(
  parameter int StartWaitCycles = tcs_pkg::SERIAL_CYCLES,
  parameter int WriteWaitCycles = tcs_pkg::WRITE_CYCLES,
  parameter int QuarterCycles   = tcs_pkg::QUARTER_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  output var  logic        irq,
  tcs_link_if.host         link
);

  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_ACK,
    M_STOP,
    M_WAIT
  } tcs_mst_e;

  typedef struct packed {
    logic [1:0]  fltS;
    logic [1:0]  losS;
    logic [1:0]  sdaS;
    logic        fltPrev;
    logic        losPrev;
    logic        dPend;
    logic        dWrite;
    logic [7:0]  dAddr;
    logic [31:0] rdata;
    logic        hreadyOut;
    logic        irq;
    logic        hwOff;
    logic [11:0] clrCnt;
    logic        txd;
    logic        busy;
    logic        rd;
    logic        diag;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [7:0]  rdByte;
    logic        nack;
    tcs_mst_e    st;
    logic [1:0]  q;
    logic [9:0]  div;
    logic [2:0]  bitN;
    logic [1:0]  idx;
    logic [7:0]  sh;
    logic        scl;
    logic        sdaLow;
    logic [31:0] waitCnt;
    logic [2:0]  evt;
    logic [2:0]  mask;
  } tcs_host_s;

  tcs_host_s s_ff;
  tcs_host_s nxt_s;

  function automatic logic [7:0] txByte(input tcs_host_s s, input logic [1:0] idx);
    logic [6:0] dev;
    dev = s.diag ? tcs_pkg::DIAG_DEV : tcs_pkg::ID_DEV;
    case (idx)
      2'h0:    txByte = {dev, 1'b0};
      2'h1:    txByte = s.addr;
      2'h2:    txByte = s.rd ? {dev, 1'b1} : s.data;
      default: txByte = 8'hFF;
    endcase
  endfunction

  always_comb begin
    logic       tick;
    logic       sdaIn;
    logic [2:0] evtSet;
    logic [2:0] rdClr;
    tick   = s_ff.div == 10'(QuarterCycles - 1);
    sdaIn  = s_ff.sdaS[1];
    evtSet = 3'h0;
    rdClr  = 3'h0;
    nxt_s  = s_ff;

    nxt_s.fltS    = {s_ff.fltS[0], link.txFault};
    nxt_s.losS    = {s_ff.losS[0], link.rxSignalLost};
    nxt_s.sdaS    = {s_ff.sdaS[0], link.sda};
    nxt_s.fltPrev = s_ff.fltS[1];
    nxt_s.losPrev = s_ff.losS[1];
    evtSet[tcs_pkg::EVT_FAULT] = s_ff.fltS[1] && !s_ff.fltPrev;
    evtSet[tcs_pkg::EVT_LOS]   = s_ff.losS[1] ^ s_ff.losPrev;

    // Address phase: read data is ready for the data phase
    nxt_s.dPend     = hsel && htrans[1] && hready;
    nxt_s.dWrite    = hwrite;
    nxt_s.dAddr     = haddr[7:0];
    nxt_s.rdata     = 32'h0;
    nxt_s.hreadyOut = 1'b1;
    if (nxt_s.dPend && !hwrite) begin
      case (haddr[7:0])
        tcs_pkg::CTRL_OFS: nxt_s.rdata = {31'h0, s_ff.hwOff};
        tcs_pkg::STAT_OFS: nxt_s.rdata = {16'h0, s_ff.rdByte, 4'h0, s_ff.nack,
                                          s_ff.losS[1], s_ff.fltS[1], s_ff.busy};
        tcs_pkg::EVT_OFS: begin
          nxt_s.rdata = {29'h0, s_ff.evt};
          rdClr       = s_ff.evt;
        end
        tcs_pkg::MASK_OFS: nxt_s.rdata = {29'h0, s_ff.mask};
        default:           nxt_s.rdata = 32'h0;
      endcase
    end

    if (s_ff.clrCnt != 12'h000) begin
      nxt_s.clrCnt = s_ff.clrCnt - 12'h001;
    end

    // Two-wire master, four quarters per bus bit
    case (s_ff.st)
      M_WAIT: begin
        if (s_ff.waitCnt == 32'h0) begin
          nxt_s.st = M_IDLE;
          nxt_s.busy = 1'b0;
          evtSet[tcs_pkg::EVT_DONE] = 1'b1;
        end else begin
          nxt_s.waitCnt = s_ff.waitCnt - 32'h1;
        end
      end
      M_START, M_BIT, M_ACK, M_STOP: begin
        nxt_s.div = tick ? 10'h000 : s_ff.div + 10'h001;
        if (tick) begin
          nxt_s.q = s_ff.q + 2'h1;
          if (s_ff.q == 2'h2 && s_ff.st == M_BIT) begin
            nxt_s.sh = {s_ff.sh[6:0], sdaIn};
          end
          if (s_ff.q == 2'h2 && s_ff.st == M_ACK && s_ff.idx != 2'h3) begin
            nxt_s.nack = sdaIn;
          end
          if (s_ff.q == 2'h3) begin
            case (s_ff.st)
              M_START: begin
                nxt_s.st   = M_BIT;
                nxt_s.bitN = 3'h0;
                nxt_s.sh   = txByte(s_ff, s_ff.idx);
              end
              M_BIT: begin
                if (s_ff.bitN == tcs_pkg::LAST_BIT) begin
                  nxt_s.st = M_ACK;
                  if (s_ff.idx == 2'h3) begin
                    nxt_s.rdByte = s_ff.sh;
                  end
                end else begin
                  nxt_s.bitN = s_ff.bitN + 3'h1;
                end
              end
              M_ACK: begin
                if (s_ff.nack || s_ff.idx == 2'h3 || (s_ff.idx == 2'h2 && !s_ff.rd)) begin
                  nxt_s.st = M_STOP;
                end else if (s_ff.idx == 2'h1 && s_ff.rd) begin
                  nxt_s.st  = M_START;
                  nxt_s.idx = 2'h2;
                end else begin
                  nxt_s.st   = M_BIT;
                  nxt_s.idx  = s_ff.idx + 2'h1;
                  nxt_s.bitN = 3'h0;
                  nxt_s.sh   = txByte(s_ff, s_ff.idx + 2'h1);
                end
              end
              default: begin
                nxt_s.st = M_WAIT;
                // Longer gap after a write lets the module finish it
                nxt_s.waitCnt = (!s_ff.rd && !s_ff.nack) ? 32'(WriteWaitCycles)
                                                          : 32'(tcs_pkg::BUF_CYCLES);
              end
            endcase
          end
        end
      end
      default: ;
    endcase

    // Data phase writes
    if (s_ff.dPend && s_ff.dWrite) begin
      case (s_ff.dAddr)
        tcs_pkg::CTRL_OFS: begin
          nxt_s.hwOff = hwdata[tcs_pkg::CTRL_HWOFF_BIT];
          if (hwdata[tcs_pkg::CTRL_CLEAR_BIT]) begin
            nxt_s.clrCnt = 12'(tcs_pkg::RESET_CYCLES);
          end
        end
        tcs_pkg::CMD_OFS: begin
          // Refused while busy, including the start-up wait
          if (!s_ff.busy) begin
            nxt_s.busy = 1'b1;
            nxt_s.data = hwdata[7:0];
            nxt_s.addr = hwdata[tcs_pkg::CMD_ADDR_LSB +: 8];
            nxt_s.rd   = hwdata[tcs_pkg::CMD_RD_BIT];
            nxt_s.diag = hwdata[tcs_pkg::CMD_DIAG_BIT];
            nxt_s.st   = M_START;
            nxt_s.q    = 2'h0;
            nxt_s.div  = 10'h000;
            nxt_s.idx  = 2'h0;
            nxt_s.nack = 1'b0;
          end
        end
        tcs_pkg::MASK_OFS: nxt_s.mask = hwdata[2:0];
        default: ;
      endcase
    end
    nxt_s.txd = nxt_s.hwOff || nxt_s.clrCnt != 12'h000;

    // Pin levels for the coming quarter; SDA moves while SCL is low, except at start and stop
    case (nxt_s.st)
      M_START: begin
        nxt_s.scl    = nxt_s.q == 2'h1 || nxt_s.q == 2'h2;
        nxt_s.sdaLow = nxt_s.q[1];
      end
      M_BIT: begin
        nxt_s.scl = nxt_s.q == 2'h1 || nxt_s.q == 2'h2;
        if (nxt_s.q == 2'h0) begin
          nxt_s.sdaLow = !nxt_s.sh[7];
        end
      end
      M_ACK: begin
        nxt_s.scl = nxt_s.q == 2'h1 || nxt_s.q == 2'h2;
        if (nxt_s.q == 2'h0) begin
          nxt_s.sdaLow = 1'b0;
        end
      end
      M_STOP: begin
        nxt_s.scl    = nxt_s.q != 2'h0;
        nxt_s.sdaLow = !nxt_s.q[1];
      end
      default: begin
        nxt_s.scl    = 1'b1;
        nxt_s.sdaLow = 1'b0;
      end
    endcase

    // A new event wins over the clearing read
    nxt_s.evt = (s_ff.evt & ~rdClr) | evtSet;
    nxt_s.irq = |(nxt_s.evt & nxt_s.mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff           <= '0;
      s_ff.hreadyOut <= 1'b1;
      s_ff.scl       <= 1'b1;
      s_ff.busy      <= 1'b1;
      s_ff.st        <= M_WAIT;
      s_ff.waitCnt   <= 32'(StartWaitCycles);
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hreadyout       = s_ff.hreadyOut;
  assign hrdata          = s_ff.rdata;
  assign hresp           = 1'b0;
  assign irq             = s_ff.irq;
  assign link.txDisable  = s_ff.txd;
  assign link.scl        = s_ff.scl;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe  = s_ff.sdaLow;

endmodule

`default_nettype wire

// ==== testbench/tcs_link_chk.sv ====
// Checker on the link pins and the module end's optical controls.
// Assumes one clock domain; placed beside the link in the bench.
`default_nettype none

module tcs_link_chk #(
  parameter int BusReadyCycles = 2000,
  parameter int QuarterCycles  = tcs_pkg::QUARTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic txDisable,
  input wire logic txFault,
  input wire logic rxSignalLost,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaDevOe,
  input wire logic laserFault,
  input wire logic opticalPresent,
  input wire logic laserOn
);
  logic [15:0] sclRun_ff;
  logic [15:0] idleRun_ff;
  logic [15:0] upTime_ff;
  logic        sclQ_ff;
  logic        sdaQ_ff;
  logic        busStop;
  logic        busStart;

  assign busStop  = scl && sclQ_ff && sda && !sdaQ_ff;
  assign busStart = scl && sclQ_ff && !sda && sdaQ_ff;

  // Counters saturate so long idle stretches never wrap into false hits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclRun_ff  <= 16'h0000;
      idleRun_ff <= 16'hFFFF;
      upTime_ff  <= 16'h0000;
      sclQ_ff    <= 1'h1;
      sdaQ_ff    <= 1'h1;
    end else begin
      sclRun_ff  <= (scl != sclQ_ff) ? 16'h0000 : sclRun_ff + {15'h0000, sclRun_ff != 16'hFFFF};
      idleRun_ff <= busStop ? 16'h0000 : idleRun_ff + {15'h0000, idleRun_ff != 16'hFFFF};
      upTime_ff  <= upTime_ff + {15'h0000, upTime_ff != 16'hFFFF};
      sclQ_ff    <= scl;
      sdaQ_ff    <= sda;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_hwOff;
    $rose(txDisable) |-> ##[1:4] !laserOn;
  endproperty
  a_hwOff: assert property (p_hwOff) else $error("light stays on after off pin");

  property p_faultPin;
    $rose(laserFault) |-> ##[1:4] txFault;
  endproperty
  a_faultPin: assert property (p_faultPin) else $error("fault pin late");

  property p_faultHold;
    (!txDisable)[*5] ##0 txFault |=> txFault;
  endproperty
  a_faultHold: assert property (p_faultHold) else $error("fault cleared without off");

  property p_faultDark;
    txFault[*2] |-> !laserOn;
  endproperty
  a_faultDark: assert property (p_faultDark) else $error("light on during fault");

  property p_losOn;
    $fell(opticalPresent) |-> ##[1:4] rxSignalLost;
  endproperty
  a_losOn: assert property (p_losOn) else $error("signal lost pin late");

  property p_losOff;
    $rose(opticalPresent) |-> ##[1:4] !rxSignalLost;
  endproperty
  a_losOff: assert property (p_losOff) else $error("signal lost pin stuck");

  property p_sclHigh;
    $fell(scl) |-> int'(sclRun_ff) >= 2 * QuarterCycles - 1;
  endproperty
  a_sclHigh: assert property (p_sclHigh) else $error("bus clock too fast");

  property p_busIdle;
    busStart |-> idleRun_ff >= 16'd3990;
  endproperty
  a_busIdle: assert property (p_busIdle) else $error("bus idle too short");

  property p_lateAck;
    (int'(upTime_ff) < BusReadyCycles) |-> !sdaDevOe;
  endproperty
  a_lateAck: assert property (p_lateAck) else $error("device answered too early");
endmodule

`default_nettype wire

// ==== testbench/transceiver_control_status_bench.sv ====
// Bench: both ends joined by the link; software side over AHB-Lite.
// Assumes the shortened start-up, write-cycle and bus-bit counts set below.
`default_nettype none

module transceiver_control_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUS_RDY = 2000;
  // Bus bit shortened to 400 cycles; the full rate would not fit the run budget
  localparam int QUARTER = 100;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic        laserFault, opticalPresent, laserOn, monitorReady;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;

  tcs_link_if link ();
  // Host wait kept at the bus idle time so back-to-back commands stay legal
  tcs_host_end #(.StartWaitCycles(BUS_RDY), .WriteWaitCycles(4000), .QuarterCycles(QUARTER))
    tcs_host_end_i (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp(hresp), .irq, .link(link));
  tcs_module_end #(.BusReadyCycles(BUS_RDY), .DataReadyCycles(3000), .WriteCycles(1000))
    tcs_module_end_i (.clk, .rst_n, .link(link), .laserFault, .opticalPresent, .laserOn,
    .monitorReady);
  tcs_link_chk #(.BusReadyCycles(BUS_RDY), .QuarterCycles(QUARTER)) tcs_link_chk_i (.clk, .rst_n,
    .txDisable(link.txDisable), .txFault(link.txFault), .rxSignalLost(link.rxSignalLost),
    .scl(link.scl), .sda(link.sda), .sdaDevOe(link.sdaDevOe), .laserFault, .opticalPresent,
    .laserOn);

  task automatic summarize();
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic busCycle(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    busCycle(1'h1, a, d, unused);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    busCycle(1'h0, a, 32'h00000000, d);
    chk(d, exp);
  endtask

  task automatic waitIdle();
    logic [31:0] s;
    s = 32'h00000001;
    while (s[0] !== 1'h0) busCycle(1'h0, tcs_pkg::STAT_OFS, 32'h00000000, s);
  endtask

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    // Traffic takes about 55k cycles; ceiling leaves margin
    if (cycles == 100000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    {rst_n, hsel, hwrite, laserFault, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    opticalPresent = 1'h1;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rdChk(tcs_pkg::CTRL_OFS, 32'h00000000);
    chkBit(hresp, 1'h0);
    rdChk(8'h20, 32'h00000000);
    // Refused during the start-up wait: light must stay on
    wr(tcs_pkg::CMD_OFS, 32'h00026E40);
    wr(tcs_pkg::MASK_OFS, 32'h00000007);
    rdChk(tcs_pkg::MASK_OFS, 32'h00000007);
    waitIdle();
    chkBit(irq, 1'h1);
    rdChk(tcs_pkg::EVT_OFS, 32'h00000001);
    chkBit(laserOn, 1'h1);
    wr(tcs_pkg::CMD_OFS, 32'h00026E40);
    // Read while busy is refused; last read byte below stays zero
    wr(tcs_pkg::CMD_OFS, 32'h00036E00);
    waitIdle();
    chkBit(laserOn, 1'h0);
    laserFault <= 1'h1;
    opticalPresent <= 1'h0;
    @(posedge clk);
    laserFault <= 1'h0;
    repeat (8) @(posedge clk);
    chkBit(link.txFault, 1'h1);
    chkBit(link.rxSignalLost, 1'h1);
    rdChk(tcs_pkg::STAT_OFS, 32'h00000006);
    rdChk(tcs_pkg::EVT_OFS, 32'h00000007);
    wr(tcs_pkg::CMD_OFS, 32'h00036E00);
    waitIdle();
    rdChk(tcs_pkg::STAT_OFS, 32'h00004706);
    chkBit(monitorReady, 1'h1);
    opticalPresent <= 1'h1;
    wr(tcs_pkg::CTRL_OFS, 32'h00000002);
    repeat (2100) @(posedge clk);
    chkBit(link.txFault, 1'h0);
    chkBit(link.rxSignalLost, 1'h0);
    wr(tcs_pkg::CMD_OFS, 32'h00026E00);
    waitIdle();
    chkBit(laserOn, 1'h1);
    wr(tcs_pkg::CTRL_OFS, 32'h00000001);
    repeat (8) @(posedge clk);
    chkBit(laserOn, 1'h0);
    wr(tcs_pkg::CTRL_OFS, 32'h00000000);
    repeat (8) @(posedge clk);
    chkBit(laserOn, 1'h1);
    summarize();
  end
endmodule

`default_nettype wire
